// File: rdt_pkg.sv
package rdt_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] RDT_OFS_CLOCK = 8'h00;
    localparam logic [7:0] RDT_OFS_MODE = 8'h04;
    localparam logic [7:0] RDT_OFS_CTRL = 8'h08;
    localparam logic [7:0] RDT_OFS_RELOAD = 8'h0C;
    localparam logic [7:0] RDT_OFS_COUNT = 8'h10;
    localparam logic [7:0] RDT_OFS_FLAG = 8'h14;
    localparam logic [7:0] RDT_OFS_IRQEN = 8'h18;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int RDT_BIT_DEBUG_RUN_ENABLE = 8;
    localparam int RDT_DIV_LO = 4;
    localparam int RDT_BIT_RUN = 8;
    localparam int RDT_BIT_LOAD = 1;
    localparam int RDT_BIT_EN = 0;
    localparam int RDT_BIT_ONESHOT = 0;
    localparam int RDT_BIT_UF = 0;
    localparam int RDT_BIT_UNDERFLOW_IRQ_ENABLE = 0;
    localparam logic [15:0] RDT_RELOAD_RST = 16'hFFFF;
    localparam logic [15:0] RDT_COUNT_RST = 16'hFFFF;
    localparam logic [15:0] RDT_COUNT_ZERO = 16'h0000;
    localparam logic [15:0] RDT_ONE = 16'h0001;
    localparam logic [3:0] RDT_DIV_LS_MAX = 4'h8;
    localparam logic [14:0] RDT_PRE_ONE = 15'h0001;

    // ************************************************************
    // clock sources
    // ************************************************************
    localparam logic [1:0] RDT_SRC_INT = 2'h0;
    localparam logic [1:0] RDT_SRC_LOW = 2'h1;
    localparam logic [1:0] RDT_SRC_HIGH = 2'h2;
    localparam logic [1:0] RDT_SRC_EXT = 2'h3;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic debug_run_enable;
        logic [3:0] clock_divider_select;
        logic [1:0] clock_source_select;
    } rdt_clk_cfg_t;

    typedef struct packed {
        logic internal_osc;
        logic low_speed_osc;
        logic high_speed_osc;
        logic external_clock_in;
        logic event_input_pin;
    } rdt_src_t;

endpackage

// File: rdt_tick_gen.sv
`timescale 1ns/100ps
module rdt_tick_gen
    import rdt_pkg::*;
#(
    parameter bit EVENT_CHANNEL = 1'b0
)
(
    input wire logic clk,
    input wire logic srst,
    input wire rdt_clk_cfg_t cfg,
    input wire rdt_src_t src,
    input wire logic debug_mode,
    input wire logic enable,
    output logic tick
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        rdt_src_t sync1;
        rdt_src_t sync2;
        rdt_src_t prev;
        logic [14:0] prescale;
    } rdt_tick_state_t;

    rdt_tick_state_t state_reg;
    rdt_tick_state_t state_next;
    logic [4:0] edges;
    logic src_edge;
    logic gate;
    logic [14:0] div_mask;

    // rising edges of each synchronised source
    assign edges = state_reg.sync2 & ~state_reg.prev;

    // pick the source edge; undivided external or event input
    always_comb
    begin
        case (cfg.clock_source_select)
            RDT_SRC_INT: src_edge = edges[4];
            RDT_SRC_LOW: src_edge = edges[3];
            RDT_SRC_HIGH: src_edge = edges[2];
            RDT_SRC_EXT: src_edge = EVENT_CHANNEL ? edges[0] : edges[1];
            default: src_edge = 1'b0;
        endcase
    end

    // clock withheld in debug unless debug run set, or channel disabled
    assign gate = enable && (!debug_mode || cfg.debug_run_enable);

    // divide ratio 2^div as a mask on the prescaler
    assign div_mask = (cfg.clock_source_select == RDT_SRC_EXT) ? 15'h0000
        : 15'((RDT_PRE_ONE << cfg.clock_divider_select) - RDT_PRE_ONE);

    // prescaler and synchronisers
    always_comb
    begin
        state_next = state_reg;
        state_next.sync1 = src;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = state_reg.sync2;
        tick = 1'b0;
        if (gate && src_edge)
        begin
            if ((state_reg.prescale & div_mask) == div_mask)
            begin
                tick = 1'b1;
                state_next.prescale = 15'h0000;
            end
            else
            begin
                state_next.prescale = 15'(state_reg.prescale + RDT_PRE_ONE);
            end
        end
    end

    // register
    always_ff @(posedge clk)
    begin
        if (srst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

endmodule

// File: rdt_timer.sv
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// - debug run bit keeps clock in debug
// - divider field selects power-of-two division
// - source field picks counting clock
// - unimplemented source codes are refused
// - code three uses event or external input
// - mode bit selects one-shot or repeat
// - run bit starts, stops, reads running
// - one-shot underflow clears run bit
// - load bit presets counter, self-clears
// - enable bit gates channel clock
// - reload resets all ones, loaded on underflow
// - count register reads live counter
// - underflow flag sets, write one clears
// - interrupt enable bit gates interrupts
// - repeat mode reloads and keeps counting
// - period is reload plus one ticks
// - request while flag and enable set
// - event channel counts event rising edges
module rdt_timer
    import rdt_pkg::*;
#(
    parameter bit EVENT_CHANNEL = 1'b0,
    parameter logic [3:0] SRC_PRESENT = 4'hF
)
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic INTERNAL_OSC,
    input wire logic LOW_SPEED_OSC,
    input wire logic HIGH_SPEED_OSC,
    input wire logic EXTERNAL_CLOCK_IN,
    input wire logic EVENT_INPUT_PIN,
    input wire logic DEBUG_MODE,
    output logic UNDERFLOW_IRQ,
    output logic UNDERFLOW_PULSE
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        rdt_clk_cfg_t clk_cfg;
        logic one_shot_select;
        logic run_bit;
        logic load_bit;
        logic channel_enable;
        logic [15:0] reload_field;
        logic [15:0] count_field;
        logic underflow_flag;
        logic underflow_irq_enable;
        logic uf_pulse;
        logic debug_s1;
        logic debug_s2;
    } rdt_state_t;

    rdt_state_t state_reg;
    rdt_state_t state_next;
    logic tick;
    logic take;
    logic underflow;
    logic [15:0] wdata;
    rdt_src_t src;

    assign src = '{internal_osc: INTERNAL_OSC, low_speed_osc: LOW_SPEED_OSC,
        high_speed_osc: HIGH_SPEED_OSC, external_clock_in: EXTERNAL_CLOCK_IN,
        event_input_pin: EVENT_INPUT_PIN};

    // ************************************************************
    // counter clock
    // ************************************************************
    rdt_tick_gen #(
        .EVENT_CHANNEL(EVENT_CHANNEL)
    ) u_tick (
        .clk(CLK),
        .srst(SRST),
        .cfg(state_reg.clk_cfg),
        .src(src),
        .debug_mode(state_reg.debug_s2),
        .enable(state_reg.channel_enable),
        .tick(tick)
    );

    // ************************************************************
    // bus slave: zero wait states, always okay
    // ************************************************************
    assign take = HSEL && HREADY && HTRANS[1];
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = state_reg.rdata;
    assign wdata = HWDATA[15:0];
    assign UNDERFLOW_IRQ = state_reg.underflow_flag && state_reg.underflow_irq_enable;
    assign UNDERFLOW_PULSE = state_reg.uf_pulse;

    // underflow is the step taken from zero while running
    assign underflow = state_reg.run_bit && tick
        && state_reg.count_field == RDT_COUNT_ZERO;

    // next-state logic
    always_comb
    begin
        state_next = state_reg;
        state_next.debug_s1 = DEBUG_MODE;
        state_next.debug_s2 = state_reg.debug_s1;
        state_next.uf_pulse = underflow;
        state_next.load_bit = 1'b0;

        // counting
        if (state_reg.run_bit && tick)
        begin
            if (underflow)
            begin
                state_next.count_field = state_reg.reload_field;
                if (state_reg.one_shot_select)
                    state_next.run_bit = 1'b0;
            end
            else
            begin
                state_next.count_field = 16'(state_reg.count_field - RDT_ONE);
            end
        end

        // latch a preset that was requested last cycle
        if (state_reg.load_bit)
            state_next.count_field = state_reg.reload_field;

        // write data phase
        if (state_reg.wr_pend)
        begin
            case (state_reg.wr_addr)
                RDT_OFS_CLOCK:
                begin
                    state_next.clk_cfg.debug_run_enable = wdata[RDT_BIT_DEBUG_RUN_ENABLE];
                    state_next.clk_cfg.clock_divider_select =
                        (wdata[1:0] == RDT_SRC_LOW && wdata[RDT_DIV_LO +: 4] > RDT_DIV_LS_MAX)
                        ? RDT_DIV_LS_MAX : wdata[RDT_DIV_LO +: 4];
                    if (SRC_PRESENT[wdata[1:0]])
                        state_next.clk_cfg.clock_source_select = wdata[1:0];
                end
                RDT_OFS_MODE:
                    state_next.one_shot_select = wdata[RDT_BIT_ONESHOT];
                RDT_OFS_CTRL:
                begin
                    state_next.channel_enable = wdata[RDT_BIT_EN];
                    if (wdata[RDT_BIT_EN])
                    begin
                        state_next.run_bit = wdata[RDT_BIT_RUN];
                        if (wdata[RDT_BIT_LOAD])
                            state_next.load_bit = 1'b1;
                    end
                    else
                    begin
                        state_next.run_bit = 1'b0;
                    end
                end
                RDT_OFS_RELOAD:
                    state_next.reload_field = wdata;
                RDT_OFS_IRQEN:
                    state_next.underflow_irq_enable = wdata[RDT_BIT_UNDERFLOW_IRQ_ENABLE];
                default:
                    state_next.wr_pend = 1'b0;
            endcase
        end

        // flag: write one clears, a new underflow wins
        if (state_reg.wr_pend && state_reg.wr_addr == RDT_OFS_FLAG && wdata[RDT_BIT_UF])
            state_next.underflow_flag = 1'b0;
        if (underflow)
            state_next.underflow_flag = 1'b1;

        // address phase
        state_next.wr_pend = take && HWRITE;
        state_next.wr_addr = HADDR[7:0];
        state_next.rdata = 32'h00000000;
        if (take && !HWRITE)
        begin
            case (HADDR[7:0])
                RDT_OFS_CLOCK:
                    state_next.rdata = {23'h000000, state_reg.clk_cfg.debug_run_enable,
                        state_reg.clk_cfg.clock_divider_select, 2'h0,
                        state_reg.clk_cfg.clock_source_select};
                RDT_OFS_MODE:
                    state_next.rdata = {31'h00000000, state_reg.one_shot_select};
                RDT_OFS_CTRL:
                    state_next.rdata = {23'h000000, state_reg.run_bit, 6'h00,
                        state_reg.load_bit, state_reg.channel_enable};
                RDT_OFS_RELOAD:
                    state_next.rdata = {16'h0000, state_reg.reload_field};
                RDT_OFS_COUNT:
                    state_next.rdata = {16'h0000, state_reg.count_field};
                RDT_OFS_FLAG:
                    state_next.rdata = {31'h00000000, state_reg.underflow_flag};
                RDT_OFS_IRQEN:
                    state_next.rdata = {31'h00000000, state_reg.underflow_irq_enable};
                default:
                    state_next.rdata = 32'h00000000;
            endcase
        end
    end

    // register
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_reg <= '0;
            state_reg.reload_field <= RDT_RELOAD_RST;
            state_reg.count_field <= RDT_COUNT_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

endmodule

// File: rdt_timer_asserts.sv
`timescale 1ns/100ps
module rdt_timer_asserts
    import rdt_pkg::*;
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic UNDERFLOW_IRQ,
    input wire logic UNDERFLOW_PULSE
);
    // ****
    // data phase tracking
    // ****
    logic wr_reg;
    logic rd_reg;
    logic [7:0] addr_reg;

    // remember the transfer taken at the last edge
    always_ff @(posedge CLK)
    begin
        wr_reg <= !SRST && HSEL && HREADY && HTRANS[1] && HWRITE;
        rd_reg <= !SRST && HSEL && HREADY && HTRANS[1] && !HWRITE;
        addr_reg <= HADDR[7:0];
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    // ****
    // properties
    // ****
    AST_OKAY: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not ready or not okay");
    AST_UPPER_ZERO: assert property (HRDATA[31:16] == 16'h0000)
        else $error("upper read data not zero");
    AST_IDLE_ZERO: assert property (!rd_reg |-> HRDATA == 32'h0)
        else $error("read data outside a read");
    AST_CTRL_RSVD: assert property (rd_reg && addr_reg == RDT_OFS_CTRL |-> (HRDATA & 32'h0000FEFC) == 32'h0)
        else $error("control reserved bits not zero");
    AST_UNMAPPED: assert property (rd_reg && addr_reg > RDT_OFS_IRQEN |-> HRDATA == 32'h0)
        else $error("unmapped read not zero");
    AST_IRQ_OFF: assert property (wr_reg && addr_reg == RDT_OFS_IRQEN && !HWDATA[0] |=> !UNDERFLOW_IRQ)
        else $error("request while disabled");
    AST_FLAG_CLR: assert property (wr_reg && addr_reg == RDT_OFS_FLAG && HWDATA[0] |=> !UNDERFLOW_IRQ || UNDERFLOW_PULSE)
        else $error("flag not cleared by write one");
    AST_IRQ_FALL: assert property ($fell(UNDERFLOW_IRQ) |-> $past(wr_reg))
        else $error("request dropped without a write");
    AST_IRQ_RISE: assert property ($rose(UNDERFLOW_IRQ) |-> UNDERFLOW_PULSE || $past(wr_reg))
        else $error("request raised without cause");
    AST_PULSE_ONE: assert property (UNDERFLOW_PULSE |=> !UNDERFLOW_PULSE)
        else $error("underflow pulse longer than one cycle");

    cover property (UNDERFLOW_PULSE);
    cover property ($rose(UNDERFLOW_IRQ));
    cover property (rd_reg && addr_reg == RDT_OFS_COUNT);
endmodule

bind rdt_timer rdt_timer_asserts chk_u (.CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .UNDERFLOW_IRQ(UNDERFLOW_IRQ),
    .UNDERFLOW_PULSE(UNDERFLOW_PULSE));

// File: test_reload_down_timer_channel.sv
`timescale 1ns/100ps
module test_reload_down_timer_channel import rdt_pkg::*;;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rv;
    logic hready;
    logic [5:0] osc = 6'h00;
    logic dbg = 1'b0;
    logic irq;
    logic pulse;
    logic pulse_ev;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;

    rdt_timer dut_u (.CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(), .INTERNAL_OSC(osc[2]), .LOW_SPEED_OSC(osc[3]),
        .HIGH_SPEED_OSC(osc[4]), .EXTERNAL_CLOCK_IN(osc[5]), .EVENT_INPUT_PIN(osc[1]),
        .DEBUG_MODE(dbg), .UNDERFLOW_IRQ(irq), .UNDERFLOW_PULSE(pulse));

    // event-counting channel with source code 2 absent, on the same bus writes
    rdt_timer #(.EVENT_CHANNEL(1'b1), .SRC_PRESENT(4'hB)) dut_ev (.CLK(clk), .SRST(srst),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hready), .HRDATA(), .HREADYOUT(), .HRESP(),
        .INTERNAL_OSC(osc[2]), .LOW_SPEED_OSC(osc[3]), .HIGH_SPEED_OSC(osc[4]),
        .EXTERNAL_CLOCK_IN(osc[5]), .EVENT_INPUT_PIN(osc[1]), .DEBUG_MODE(dbg),
        .UNDERFLOW_IRQ(), .UNDERFLOW_PULSE(pulse_ev));

    always #50 clk = ~clk;

    // source levels: event 4, internal 8, low 16, high 32, external 64 cycles; hang limit
    always @(posedge clk)
    begin
        osc <= osc + 6'h01;
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_mismatch++;
            stop_test;
        end
    end

    // ****
    // tasks
    // ****
    task stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input string s, input logic [31:0] seen, input logic [31:0] e);
        tests_run++;
        if (seen !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", s, e, seen);
            n_mismatch++;
        end
    endtask

    // one single word transfer, read data left in rv
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rv = hrdata;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e, input string s);
        bus(1'b0, a, 32'h0);
        chk(s, rv, e);
    endtask

    // cycles up to the next underflow pulse, 400 if none
    task gap(input logic ev, output int k);
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while ((ev ? pulse_ev : pulse) !== 1'b1 && k < 400);
    endtask

    // restart with a clock setting and measure one full period
    task per(input logic [31:0] c, input int e);
        bus(1'b1, RDT_OFS_CTRL, 32'h1);
        bus(1'b1, RDT_OFS_CLOCK, c);
        bus(1'b1, RDT_OFS_CTRL, 32'h103);
        gap(1'b0, n);
        gap(1'b0, n);
        chk("period", n, e);
    endtask

    // ****
    // main sequence
    // ****
    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rdc(RDT_OFS_CLOCK, 32'h0, "clock");
        rdc(RDT_OFS_MODE, 32'h0, "mode");
        rdc(RDT_OFS_CTRL, 32'h0, "ctrl");
        rdc(RDT_OFS_RELOAD, 32'h0000FFFF, "reload");
        rdc(RDT_OFS_COUNT, 32'h0000FFFF, "count");
        rdc(RDT_OFS_FLAG, 32'h0, "flag");
        rdc(RDT_OFS_IRQEN, 32'h0, "irqen");
        // reserved bits, read-only count, unmapped place, low-speed clamp
        bus(1'b1, RDT_OFS_CLOCK, 32'hFFFFFFFF);
        rdc(RDT_OFS_CLOCK, 32'h000001F3, "clock bits");
        bus(1'b1, RDT_OFS_MODE, 32'hFFFFFFFF);
        rdc(RDT_OFS_MODE, 32'h1, "mode bits");
        bus(1'b1, RDT_OFS_COUNT, 32'h1234);
        rdc(RDT_OFS_COUNT, 32'h0000FFFF, "count ro");
        bus(1'b1, 8'h1C, 32'hFFFFFFFF);
        rdc(8'h1C, 32'h0, "unmapped");
        bus(1'b1, RDT_OFS_CLOCK, 32'h000000F1);
        rdc(RDT_OFS_CLOCK, 32'h00000081, "low clamp");
        // run and load refused while disabled
        bus(1'b1, RDT_OFS_MODE, 32'h0);
        bus(1'b1, RDT_OFS_RELOAD, 32'h1);
        bus(1'b1, RDT_OFS_CTRL, 32'h102);
        rdc(RDT_OFS_COUNT, 32'h0000FFFF, "no enable");
        rdc(RDT_OFS_CTRL, 32'h0, "run off");
        // repeat mode periods over sources and dividers
        per(32'h000, 16);
        per(32'h001, 32);
        per(32'h002, 64);
        per(32'h003, 128);
        gap(1'b1, n);
        gap(1'b1, n);
        chk("event period", n, 8);
        per(32'h002, 64);
        gap(1'b1, n);
        gap(1'b1, n);
        chk("refused source", n, 8);
        per(32'h020, 64);
        per(32'h0F3, 128);
        bus(1'b1, RDT_OFS_CTRL, 32'h1);
        bus(1'b1, RDT_OFS_RELOAD, 32'h3);
        per(32'h000, 32);
        rdc(RDT_OFS_CTRL, 32'h101, "running");
        rdc(RDT_OFS_FLAG, 32'h1, "flag set");
        // stop, then request against flag and enable
        bus(1'b1, RDT_OFS_CTRL, 32'h1);
        bus(1'b0, RDT_OFS_COUNT, 32'h0);
        n = rv;
        repeat (40) @(posedge clk);
        rdc(RDT_OFS_COUNT, n, "stopped");
        bus(1'b1, RDT_OFS_IRQEN, 32'h1);
        @(posedge clk);
        chk("irq on", irq, 1'b1);
        bus(1'b1, RDT_OFS_FLAG, 32'h0);
        @(posedge clk);
        chk("irq kept", irq, 1'b1);
        bus(1'b1, RDT_OFS_IRQEN, 32'h0);
        @(posedge clk);
        chk("irq masked", irq, 1'b0);
        bus(1'b1, RDT_OFS_IRQEN, 32'h1);
        bus(1'b1, RDT_OFS_FLAG, 32'h1);
        @(posedge clk);
        chk("irq cleared", irq, 1'b0);
        rdc(RDT_OFS_FLAG, 32'h0, "flag clr");
        // one-shot stops after one underflow
        bus(1'b1, RDT_OFS_MODE, 32'h1);
        bus(1'b1, RDT_OFS_RELOAD, 32'h2);
        bus(1'b1, RDT_OFS_CLOCK, 32'h0);
        bus(1'b1, RDT_OFS_CTRL, 32'h103);
        gap(1'b0, n);
        gap(1'b0, n);
        chk("one shot", n, 400);
        rdc(RDT_OFS_CTRL, 32'h1, "run clr");
        rdc(RDT_OFS_COUNT, 32'h2, "reloaded");
        chk("irq again", irq, 1'b1);
        // clear the flag before enabling, so no request follows
        bus(1'b1, RDT_OFS_IRQEN, 32'h0);
        bus(1'b1, RDT_OFS_FLAG, 32'h1);
        bus(1'b1, RDT_OFS_IRQEN, 32'h1);
        @(posedge clk);
        chk("no spurious", irq, 1'b0);
        // debug mode keeps or withholds the clock
        bus(1'b1, RDT_OFS_MODE, 32'h0);
        dbg <= 1'b1;
        per(32'h100, 24);
        per(32'h000, 400);
        stop_test;
    end
endmodule
